// >>> rtl/rfp_bitstream.sv
// radio bit-stream codec: apb registers, fifos, line coder, pins
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "rfp_cfg.svh"
// Summary of operation
// - baud coarse bits 5-4, fine 3-0, reset zero
// - config bits 7-6 choose start detection
// - config bit 5 enables line coding
// - config bit 4 selects external receive clock when the code field is NRZ
// - config bit 3 drives tx clock on pin three
// - code field picks NRZ, bi-phase or Miller
// - control irq enables 7-5, w1c status 4-2
// - enable bits 1-0 use port-config reset
// - data writes push into four-byte tx fifo
// - tx overrun bit 3, write one flushes
// - tx status full, empty, stopped bits
// - data reads pop four-byte rx fifo
// - rx overrun bit 4, write one flushes
// - rx full bit 3, start bit 2 w1c
// - rx busy bit 1, byte ready bit 0
// - start pattern register, reset zero
// - separate receive and transmit interrupt lines
// - rx pins: data, bit clock, match
// - tx pins: data on four, clock three
// - enabled block owns pins, unused get pulls
// - one chip per NRZ or uncoded bit, else two
// - external clock rising edge samples data
module rfp_bitstream #(
  parameter int BAUD_UNIT = `RFP_BAUD_UNIT,
  parameter int DEPTH     = `RFP_FIFO_DEPTH
) (
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        pconf_nrst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        radio_pin_data_in,
  input  wire logic        radio_pin_rx_clk_in,
  input  wire logic        radio_pin_match_or_txclk_in,
  output logic             radio_pin_match_or_txclk_out,
  output logic             radio_pin_match_or_txclk_oe_out,
  output logic             radio_pin_data_out,
  output logic             radio_pin_data_out_oe_out,
  output logic             pin_override_out,
  output logic      [3:0]  pin_pull_en_out,
  output logic             irq_rx_out,
  output logic             irq_tx_out
);
  logic [5:0]       baud;
  rfp_pkg::rfp_cfg_s cfg;
  logic [2:0]       rx_irq_en;
  logic [2:0]       rx_irq_stat;
  logic             rx_en;
  logic             tx_en;
  logic [7:0]       start_pattern;
  logic             acc, take, wr, rd, hit;
  logic             w_baud, w_cfg, w_ctrl, w_txd, w_txs, w_rxs, w_pat;
  logic             rd_rx;
  logic [7:0]       rmux;
  logic [15:0]      hcnt;
  logic [15:0]      hlim;
  logic [4:0]       fine_p1;
  logic             hph, htick, chip_tick, mid_tick;
  logic             two_chip, chips2;
  rfp_pkg::rfp_tx_e tx_st;
  logic [7:0]       tx_sh;
  logic [2:0]       tx_bits;
  logic             tx_chip, tx_line, tx_pb, tx_pop, tx_tail, tx_wire;
  logic [7:0]       tx_rdata;
  logic             tx_full, tx_empty, tx_ovr, tx_idle;
  rfp_pkg::rfp_rx_e rx_st;
  logic [7:0]       rx_sh;
  logic [7:0]       pat_sh;
  logic [2:0]       rx_bits;
  logic [2:0]       run;
  logic [2:0]       run_nx;
  logic             rx_chip, rx_f, rx_pc, dbit;
  logic             rx_act, ext_mode, samp, start_det, free, viol;
  logic             rx_push, rx_flush;
  logic [7:0]       rx_rdata;
  logic             rx_full, rx_empty, rx_ovr, start_found;
  logic [2:0]       src, src_q;
  logic             din, rclk_s, rclk_q, match_s, match_q;

  rfp_sync u_sync_d (
    .clk_in (core_clk_in),
    .nrst_in(nrst_in),
    .d_in   (radio_pin_data_in),
    .q_out  (din)
  );
  rfp_sync u_sync_c (
    .clk_in (core_clk_in),
    .nrst_in(nrst_in),
    .d_in   (radio_pin_rx_clk_in),
    .q_out  (rclk_s)
  );
  rfp_sync u_sync_m (
    .clk_in (core_clk_in),
    .nrst_in(nrst_in),
    .d_in   (radio_pin_match_or_txclk_in),
    .q_out  (match_s)
  );

  // apb: one wait cycle, answer registered
  assign acc    = psel_in & penable_in & ~pready_out;
  assign take   = psel_in & penable_in & pready_out;
  assign wr     = take & pwrite_in;
  assign rd     = take & ~pwrite_in;
  assign hit    = paddr_in[7:5] == 3'h0 && paddr_in[1:0] == 2'h0;
  assign w_baud = wr && paddr_in == `RFP_A_BAUD;
  assign w_cfg  = wr && paddr_in == `RFP_A_CFG;
  assign w_ctrl = wr && paddr_in == `RFP_A_CTRL;
  assign w_txd  = wr && paddr_in == `RFP_A_TXDATA;
  assign w_txs  = wr && paddr_in == `RFP_A_TXSTA;
  assign w_rxs  = wr && paddr_in == `RFP_A_RXSTA;
  assign w_pat  = wr && paddr_in == `RFP_A_PAT;
  assign rd_rx  = rd && paddr_in == `RFP_A_RXDATA;

  always_comb begin
    unique case (paddr_in)
      `RFP_A_BAUD:  rmux = {2'h0, baud};
      `RFP_A_CFG:   rmux = cfg;
      `RFP_A_CTRL:  rmux = {rx_irq_en, rx_irq_stat, rx_en, tx_en};
      `RFP_A_TXSTA: rmux = {4'h0, tx_ovr, tx_full, tx_empty, tx_idle};
      `RFP_A_RXDATA: rmux = rx_rdata;
      `RFP_A_RXSTA: rmux = {3'h0, rx_ovr, rx_full, start_found,
                            rx_st == rfp_pkg::RFP_RX_DATA &&
                            (rx_bits != 3'h0 || rx_chip), ~rx_empty};
      `RFP_A_PAT:   rmux = start_pattern;
      default:      rmux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= acc;
      pslverr_out <= acc & ~hit;
      prdata_out  <= (acc && !pwrite_in) ? {24'h00_0000, rmux} : 32'h0;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      baud          <= `RFP_BAUD_RST;
      cfg           <= `RFP_CFG_RST;
      rx_irq_en     <= 3'h0;
      start_pattern <= `RFP_PAT_RST;
    end else begin
      if (w_baud) begin
        baud <= pwdata_in[5:0];
      end
      if (w_cfg) begin
        cfg <= rfp_pkg::rfp_cfg_s'(pwdata_in[7:0]);
      end
      if (w_ctrl) begin
        rx_irq_en <= pwdata_in[7:5];
      end
      if (w_pat) begin
        start_pattern <= pwdata_in[7:0];
      end
    end
  end

  // enables survive a global reset; only port-config reset clears them
  always_ff @(posedge core_clk_in or negedge pconf_nrst_in) begin
    if (!pconf_nrst_in) begin
      rx_en <= 1'b0;
      tx_en <= 1'b0;
    end else if (w_ctrl) begin
      rx_en <= pwdata_in[`RFP_CTRL_RXEN];
      tx_en <= pwdata_in[`RFP_CTRL_TXEN];
    end
  end

  // half-chip timebase shared by both directions (half duplex)
  assign fine_p1   = {1'b0, baud[3:0]} + 5'h01;
  assign hlim      = (16'(BAUD_UNIT) * {11'h000, fine_p1})
                     << {baud[5:4], 1'b0};
  assign htick     = hcnt == hlim - 16'h0001;
  assign chip_tick = htick & hph;
  assign mid_tick  = htick & ~hph;
  assign two_chip  = cfg.line_code_type >= `RFP_PCM_BP_L;
  assign chips2    = cfg.coding_enable & two_chip;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hcnt <= 16'h0000;
      hph  <= 1'b0;
    end else if (!(tx_en || rx_en)) begin
      hcnt <= 16'h0000;
      hph  <= 1'b0;
    end else if (htick) begin
      hcnt <= 16'h0000;
      hph  <= ~hph;
    end else begin
      hcnt <= hcnt + 16'h0001;
    end
  end

  function automatic logic enc(input logic [2:0] t, input logic cod,
                               input logic b, input logic c,
                               input logic l, input logic pb);
    logic v;
    v = b;
    if (cod) begin
      unique case (t)
        `RFP_PCM_NRZ_L: v = b;
        `RFP_PCM_NRZ_M: v = b ? ~l : l;
        `RFP_PCM_NRZ_S: v = b ? l : ~l;
        `RFP_PCM_BP_L:  v = c ? ~b : b;
        `RFP_PCM_BP_M:  v = c ? (b ? ~l : l) : ~l;
        `RFP_PCM_BP_S:  v = c ? (b ? l : ~l) : ~l;
        default:        v = c ? (b ? ~l : l) : ((b | pb) ? l : ~l);
      endcase
    end
    return v;
  endfunction

  rfp_fifo #(
    .W    (8),
    .DEPTH(DEPTH)
  ) u_txf (
    .clk_in   (core_clk_in),
    .nrst_in  (nrst_in),
    .flush_in (w_txs & pwdata_in[`RFP_TXSTA_OVR]),
    .push_in  (w_txd),
    .wdata_in (pwdata_in[7:0]),
    .pop_in   (tx_pop),
    .rdata_out(tx_rdata),
    .full_out (tx_full),
    .empty_out(tx_empty)
  );

  assign tx_pop = tx_st == rfp_pkg::RFP_TX_IDLE && tx_en && !tx_empty;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_ovr  <= 1'b0;
      tx_idle <= 1'b0;
    end else begin
      tx_ovr  <= (tx_w_full(w_txd, tx_full)) |
                 (tx_ovr & ~(w_txs & pwdata_in[`RFP_TXSTA_OVR]));
      tx_idle <= tx_empty && tx_st == rfp_pkg::RFP_TX_IDLE;
    end
  end

  function automatic logic tx_w_full(input logic w, input logic f);
    return w & f;
  endfunction

  // byte goes out lsb first; line level is set at each chip boundary
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_st   <= rfp_pkg::RFP_TX_IDLE;
      tx_sh   <= 8'h00;
      tx_bits <= 3'h0;
      tx_chip <= 1'b0;
      tx_line <= 1'b0;
      tx_pb   <= 1'b0;
    end else begin
      unique case (tx_st)
        rfp_pkg::RFP_TX_IDLE: begin
          if (tx_pop) begin
            tx_st <= rfp_pkg::RFP_TX_LOAD;
          end
        end
        rfp_pkg::RFP_TX_LOAD: begin
          tx_sh   <= tx_rdata;
          tx_bits <= 3'h0;
          tx_chip <= 1'b0;
          tx_st   <= rfp_pkg::RFP_TX_SEND;
        end
        rfp_pkg::RFP_TX_SEND: begin
          if (!tx_en) begin
            tx_st <= rfp_pkg::RFP_TX_IDLE;
          end else if (chip_tick) begin
            tx_line <= enc(cfg.line_code_type, cfg.coding_enable,
                           tx_sh[0], tx_chip, tx_line, tx_pb);
            if (chips2 && !tx_chip) begin
              tx_chip <= 1'b1;
            end else begin
              tx_chip <= 1'b0;
              tx_pb   <= tx_sh[0];
              tx_sh   <= {1'b0, tx_sh[7:1]};
              tx_bits <= tx_bits + 3'h1;
              if (tx_bits == 3'h7) begin
                tx_st <= rfp_pkg::RFP_TX_IDLE;
              end
            end
          end
        end
        default: tx_st <= rfp_pkg::RFP_TX_IDLE;
      endcase
    end
  end

  // the bit clock keeps running through the last chip of a byte
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_tail <= 1'b0;
    end else if (!tx_en || chip_tick) begin
      tx_tail <= tx_en && tx_st == rfp_pkg::RFP_TX_SEND &&
                 tx_bits == 3'h7 && (!chips2 || tx_chip);
    end
  end
  assign tx_wire = tx_tail || (tx_st == rfp_pkg::RFP_TX_SEND &&
                               (tx_bits != 3'h0 || tx_chip));

  // receive sampling, start detection and decoding
  assign rx_act   = rx_en & ~tx_en;
  assign ext_mode = cfg.ext_rx_bitclk_enable & ~two_chip;
  assign samp     = ext_mode ? (rclk_s & ~rclk_q) : mid_tick;
  assign run_nx   = (din == rx_pc) ? ((run == 3'h7) ? run : run + 3'h1)
                                   : 3'h1;
  assign viol     = run_nx > ((cfg.line_code_type[2:1] == 2'h3)
                              ? `RFP_MIL_RUN : `RFP_BP_RUN);
  assign free     = cfg.start_detect_mode == rfp_pkg::RFP_ST_NONE ||
                    (cfg.start_detect_mode == rfp_pkg::RFP_ST_PROTO &&
                     !two_chip);

  always_comb begin
    unique case (cfg.start_detect_mode)
      rfp_pkg::RFP_ST_NONE:  start_det = 1'b0;
      rfp_pkg::RFP_ST_PROTO: start_det = samp & two_chip & viol;
      rfp_pkg::RFP_ST_EXT:   start_det = match_q & ~match_s;
      default: start_det = samp & ({pat_sh[6:0], din} == start_pattern);
    endcase
    start_det = start_det & rx_act;
  end

  always_comb begin
    dbit = din;
    if (cfg.coding_enable) begin
      unique case (cfg.line_code_type)
        `RFP_PCM_NRZ_L: dbit = din;
        `RFP_PCM_NRZ_M: dbit = din ^ rx_pc;
        `RFP_PCM_NRZ_S: dbit = ~(din ^ rx_pc);
        `RFP_PCM_BP_L:  dbit = rx_f;
        `RFP_PCM_BP_S:  dbit = ~(rx_f ^ din);
        default:        dbit = rx_f ^ din;
      endcase
    end
  end

  assign rx_push  = rx_st == rfp_pkg::RFP_RX_DATA && samp && !start_det &&
                    (!chips2 || rx_chip) && rx_bits == 3'h7;
  assign rx_flush = start_det | (w_rxs & pwdata_in[`RFP_RXSTA_OVR]);

  rfp_fifo #(
    .W    (8),
    .DEPTH(DEPTH)
  ) u_rxf (
    .clk_in   (core_clk_in),
    .nrst_in  (nrst_in),
    .flush_in (rx_flush),
    .push_in  (rx_push),
    .wdata_in ({dbit, rx_sh[7:1]}),
    .pop_in   (rd_rx),
    .rdata_out(rx_rdata),
    .full_out (rx_full),
    .empty_out(rx_empty)
  );

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rclk_q  <= 1'b0;
      match_q <= 1'b0;
      rx_pc   <= 1'b0;
      run     <= 3'h0;
      pat_sh  <= 8'h00;
    end else begin
      rclk_q  <= rclk_s;
      match_q <= match_s;
      if (samp) begin
        rx_pc  <= din;
        run    <= run_nx;
        pat_sh <= {pat_sh[6:0], din};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_st   <= rfp_pkg::RFP_RX_OFF;
      rx_sh   <= 8'h00;
      rx_bits <= 3'h0;
      rx_chip <= 1'b0;
      rx_f    <= 1'b0;
    end else if (!rx_act) begin
      rx_st <= rfp_pkg::RFP_RX_OFF;
    end else if (start_det) begin
      rx_st   <= rfp_pkg::RFP_RX_DATA;
      rx_bits <= 3'h0;
      rx_chip <= 1'b0;
    end else begin
      unique case (rx_st)
        rfp_pkg::RFP_RX_OFF: begin
          rx_st   <= free ? rfp_pkg::RFP_RX_DATA : rfp_pkg::RFP_RX_HUNT;
          rx_bits <= 3'h0;
          rx_chip <= 1'b0;
        end
        rfp_pkg::RFP_RX_HUNT: rx_st <= rfp_pkg::RFP_RX_HUNT;
        rfp_pkg::RFP_RX_DATA: begin
          if (samp && chips2 && !rx_chip) begin
            rx_chip <= 1'b1;
            rx_f    <= din;
          end else if (samp) begin
            rx_chip <= 1'b0;
            rx_sh   <= {dbit, rx_sh[7:1]};
            rx_bits <= rx_bits + 3'h1;
          end
        end
        default: rx_st <= rfp_pkg::RFP_RX_OFF;
      endcase
    end
  end

  // sticky flags: a new event wins over a software clear
  assign src = {rx_full, start_found, ~rx_empty};
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_ovr      <= 1'b0;
      start_found <= 1'b0;
      src_q       <= 3'h0;
      rx_irq_stat <= 3'h0;
      irq_rx_out  <= 1'b0;
      irq_tx_out  <= 1'b0;
    end else begin
      rx_ovr      <= (rx_push & rx_full) | (rx_ovr & ~rx_flush);
      start_found <= start_det | (start_found &
                     ~(w_rxs & pwdata_in[`RFP_RXSTA_SD]));
      src_q       <= src;
      rx_irq_stat <= (src & ~src_q) |
                     (rx_irq_stat & ~({3{w_ctrl}} & pwdata_in[4:2]));
      irq_rx_out  <= |(rx_irq_stat & rx_irq_en);
      irq_tx_out  <= tx_empty & tx_en;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_override_out                <= 1'b0;
      pin_pull_en_out                 <= 4'h0;
      radio_pin_data_out              <= 1'b0;
      radio_pin_data_out_oe_out       <= 1'b0;
      radio_pin_match_or_txclk_out    <= 1'b0;
      radio_pin_match_or_txclk_oe_out <= 1'b0;
    end else begin
      pin_override_out <= rx_en | tx_en;
      if (tx_en) begin
        pin_pull_en_out <= {1'b0, ~cfg.tx_bitclk_out_enable, 2'h3};
      end else begin
        pin_pull_en_out <= {rx_en, 3'h0};
      end
      radio_pin_data_out        <= tx_en & tx_line;
      radio_pin_data_out_oe_out <= tx_en;
      radio_pin_match_or_txclk_out <= tx_wire &&
                                      (chips2 ? tx_chip : hph);
      radio_pin_match_or_txclk_oe_out <= tx_en & cfg.tx_bitclk_out_enable;
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  AST_TX_OVR: assert property (w_txd && tx_full |=> tx_ovr)
    else $error("tx write while full did not flag overrun");
  AST_TX_FLUSH: assert property (w_txs && pwdata_in[3] |=> tx_empty)
    else $error("tx overrun clear did not flush fifo");
  AST_TX_IDLE: assert property ((tx_empty && !tx_en) [*4]
    |-> tx_idle)
    else $error("tx stopped flag missing");
  AST_RX_START: assert property (start_det |=> start_found && rx_empty)
    else $error("start detect did not flag and flush");
  AST_RX_OVR: assert property (rx_push && rx_full |=> rx_ovr)
    else $error("rx overrun not flagged");
  AST_PIN_OWN: assert property ((rx_en || tx_en) [*2] |-> pin_override_out)
    else $error("pins not taken over while enabled");
  AST_TXCLK: assert property (!cfg.tx_bitclk_out_enable
    |=> !radio_pin_match_or_txclk_oe_out)
    else $error("tx clock driven while disabled");
  AST_IRQ_MASK: assert property ((rx_irq_en == 3'h0) [*2] |-> !irq_rx_out)
    else $error("masked rx interrupt raised");
  AST_TX_CHIP: assert property ($changed(tx_line) |-> $past(chip_tick))
    else $error("tx line changed off a chip boundary");

  COV_TX_BYTE: cover property (tx_st == rfp_pkg::RFP_TX_SEND && tx_bits == 3'h7 && chip_tick);
  COV_START: cover property (start_det);
  COV_RX_PUSH: cover property (rx_push && !rx_full);
endmodule

// >>> rtl/rfp_cfg.svh
// offsets, field positions, encodings and reset values of the codec
`ifndef RFP_CFG_SVH
`define RFP_CFG_SVH
`define RFP_A_BAUD    8'h00
`define RFP_A_CFG     8'h04
`define RFP_A_CTRL    8'h08
`define RFP_A_TXDATA  8'h0C
`define RFP_A_TXSTA   8'h10
`define RFP_A_RXDATA  8'h14
`define RFP_A_RXSTA   8'h18
`define RFP_A_PAT     8'h1C
`define RFP_CTRL_RXEN 1
`define RFP_CTRL_TXEN 0
`define RFP_TXSTA_OVR 3
`define RFP_RXSTA_OVR 4
`define RFP_RXSTA_SD  2
`define RFP_PCM_NRZ_L 3'h0
`define RFP_PCM_NRZ_M 3'h1
`define RFP_PCM_NRZ_S 3'h2
`define RFP_PCM_BP_L  3'h3
`define RFP_PCM_BP_M  3'h4
`define RFP_PCM_BP_S  3'h5
`define RFP_BP_RUN    3'h2
`define RFP_MIL_RUN   3'h4
`define RFP_BAUD_RST  6'h00
`define RFP_CFG_RST   8'h00
`define RFP_PAT_RST   8'h00
`define RFP_BAUD_UNIT 8
`define RFP_FIFO_DEPTH 4
`endif

// >>> rtl/rfp_pkg.sv
// shared types of the radio bit-stream codec
package rfp_pkg;
  typedef enum logic [1:0] {
    RFP_ST_NONE  = 2'h0,
    RFP_ST_PROTO = 2'h1,
    RFP_ST_EXT   = 2'h2,
    RFP_ST_PAT   = 2'h3
  } rfp_start_e;
  typedef struct packed {
    rfp_start_e start_detect_mode;
    logic       coding_enable;
    logic       ext_rx_bitclk_enable;
    logic       tx_bitclk_out_enable;
    logic [2:0] line_code_type;
  } rfp_cfg_s;
  typedef enum logic [1:0] {
    RFP_TX_IDLE = 2'h0,
    RFP_TX_LOAD = 2'h1,
    RFP_TX_SEND = 2'h3
  } rfp_tx_e;
  typedef enum logic [1:0] {
    RFP_RX_OFF  = 2'h0,
    RFP_RX_HUNT = 2'h1,
    RFP_RX_DATA = 2'h3
  } rfp_rx_e;
endpackage

// >>> rtl/rfp_sync.sv
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module rfp_sync (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta  <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule

// >>> rtl/rfp_fifo.sv
// small byte fifo with registered head output
`timescale 1ns/1ps
module rfp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         flush_in,
  input  wire logic         push_in,
  input  wire logic [W-1:0] wdata_in,
  input  wire logic         pop_in,
  output logic      [W-1:0] rdata_out,
  output logic              full_out,
  output logic              empty_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   cnt;
  logic          do_push;
  logic          do_pop;
  assign full_out  = cnt == (AW+1)'(DEPTH);
  assign empty_out = cnt == '0;
  assign do_push   = push_in & ~full_out;
  assign do_pop    = pop_in & ~empty_out;
  // depth must be a power of two so the pointers wrap by themselves
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wptr <= '0;
      rptr <= '0;
      cnt  <= '0;
    end else if (flush_in) begin
      wptr <= '0;
      rptr <= '0;
      cnt  <= '0;
    end else begin
      if (do_push) begin
        wptr <= wptr + 1'b1;
      end
      if (do_pop) begin
        rptr <= rptr + 1'b1;
      end
      cnt <= cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (do_push) begin
      mem[wptr] <= wdata_in;
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem[rptr];
    end
  end
endmodule

// >>> dv/rfp_radio_model.sv
// radio transceiver model: drives receive data, bit clock and match
`timescale 1ns/1ps
module rfp_radio_model (
  input  wire logic txclk_in,
  input  wire logic txdata_in,
  output logic      data_out,
  output logic      clk_out,
  output logic      match_out
);
  logic [7:0] got_byte = 8'h00;
  int         got_bits = 0;
  // transmit side: data is taken at each rising edge of the bit clock
  always @(posedge txclk_in) begin
    got_byte <= {txdata_in, got_byte[7:1]};
    got_bits <= got_bits + 1;
  end
  initial begin
    data_out = 1'b0;
    clk_out = 1'b0;
    match_out = 1'b1;
  end
  // lsb first, data set before each clock rise; clock idles low after
  // pins move 1 ns after a core clock edge, never on it
  task automatic send(input logic [7:0] b);
    #1;
    for (int i = 0; i < 8; i++) begin
      data_out = b[i];
      #20 clk_out = 1'b1;
      #40 clk_out = 1'b0;
      #20;
    end
    data_out = ~b[7];
    #4;
  endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench of the radio bit-stream codec
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, nrst = 0, pnrst = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hEADD0B5B;
  logic rdy, err, e, dat, rclk, mtch, tclk, toe, dout, doe, ovr, irx, itx;
  logic [3:0] pull;
  int n_errors = 0, checked = 0;
  logic [7:0] q[$];
  logic [7:0] rst_v[8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h3, 8'h0, 8'h0, 8'h0};
  always #2.5 clk = ~clk;
  rfp_radio_model radio (.txclk_in(tclk), .txdata_in(dout), .data_out(dat),
                         .clk_out(rclk), .match_out(mtch));
  rfp_bitstream #(.BAUD_UNIT(1)) dut (
    .core_clk_in(clk), .nrst_in(nrst), .pconf_nrst_in(pnrst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(rdy),
    .pslverr_out(err), .radio_pin_data_in(dat), .radio_pin_rx_clk_in(rclk),
    .radio_pin_match_or_txclk_in(toe ? tclk : mtch),
    .radio_pin_match_or_txclk_out(tclk),
    .radio_pin_match_or_txclk_oe_out(toe), .radio_pin_data_out(dout),
    .radio_pin_data_out_oe_out(doe), .pin_override_out(ovr),
    .pin_pull_en_out(pull), .irq_rx_out(irx), .irq_tx_out(itx));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // apb transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (rdy === 1'b1) break;
    end
    if (n == 20) begin
      n_errors++;
      results();
    end
    rd = prdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rr(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    pnrst <= 1'b1;
    for (int i = 0; i < 8; i++) rr(8'(i * 4), 32'(rst_v[i]));
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, 8'h00, 32'hFF);
    rr(8'h00, 32'h3F);
    seed = xs(seed);
    apb(1'b1, 8'h1C, {24'h0, seed[7:0]});
    rr(8'h1C, {24'h0, seed[7:0]});
    apb(1'b1, 8'h04, 32'hF8);
    rr(8'h04, 32'hF8);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 8'h04, 32'(c));
      rr(8'h04, 32'(c));
    end
    for (int i = 0; i < 4; i++) apb(1'b1, 8'h0C, 32'(i));
    rr(8'h10, 32'h04);
    apb(1'b1, 8'h0C, 32'hAA);
    rr(8'h10, 32'h0C);
    apb(1'b1, 8'h10, 32'h08);
    rr(8'h10, 32'h03);
    apb(1'b1, 8'h00, 32'h01);
    apb(1'b1, 8'h04, 32'h08);
    apb(1'b1, 8'h08, 32'h01);
    repeat (3) @(posedge clk);
    chk({toe, doe, ovr, pull[1:0], itx}, 6'h3F);
    apb(1'b1, 8'h0C, 32'hA5);
    for (int n = 0; n < 200 && radio.got_bits < 8; n++) @(posedge clk);
    chk(32'(radio.got_bits), 32'h8);
    chk({24'h0, radio.got_byte}, 32'hA5);
    for (int n = 0; n < 100; n++) begin
      apb(1'b0, 8'h10, 32'h0);
      if (rd === 32'h3) break;
    end
    chk(rd, 32'h3);
    apb(1'b1, 8'h08, 32'h00);
    apb(1'b1, 8'h04, 32'h10);
    apb(1'b1, 8'h08, 32'h22);
    repeat (3) @(posedge clk);
    chk({ovr, doe, pull[3]}, 3'b101);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      radio.send(seed[7:0]);
      if (q.size() < 4) q.push_back(seed[7:0]);
    end
    repeat (10) @(posedge clk);
    chk(32'(irx), 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd & 32'h1D, 32'h19);
    rr(8'h08, 32'h36);
    apb(1'b1, 8'h08, 32'h3E);
    rr(8'h08, 32'h22);
    while (q.size() > 0) rr(8'h14, 32'(q.pop_front()));
    apb(1'b0, 8'h18, 32'h0);
    chk(rd & 32'h1D, 32'h10);
    apb(1'b1, 8'h18, 32'h10);
    rr(8'h18, 32'h0);
    apb(1'b1, 8'h08, 32'h00);
    apb(1'b1, 8'h1C, 32'hB4);
    apb(1'b1, 8'h04, 32'hD0);
    apb(1'b1, 8'h08, 32'h62);
    radio.send(8'h00);
    radio.send(8'h2D);
    radio.send(8'h0F);
    repeat (10) @(posedge clk);
    chk(32'(irx), 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd & 32'h1D, 32'h05);
    rr(8'h14, 32'h0F);
    apb(1'b1, 8'h18, 32'h04);
    rr(8'h18, 32'h0);
    pnrst <= 1'b0;
    @(posedge clk);
    pnrst <= 1'b1;
    rr(8'h08, 32'h6C);
    results();
  end
endmodule
